// >>> hdl/chained_dma_irq_timing.sv
// chained-block dma controller: state budgets, flags, interrupts, buffer
// assumes same-clock control inputs; cmd strobes are one-cycle pulses
`default_nettype none
module chained_dma_irq_timing (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          byte_mode,
	input  wire logic                          chained_mode,
	input  wire logic                          rx_dir,
	input  wire logic                          multi_frame,
	input  wire logic                          run_set,
	input  wire logic                          run_clear,
	input  wire logic                          abort_cmd,
	input  wire logic                          fct_clear_cmd,
	input  wire logic                          fct_enable_set,
	input  wire logic [3:0]                    irq_enable_wr,
	input  wire logic                          irq_enable_we,
	input  wire logic [3:0]                    flag_clear_w1c,
	input  wire logic [dma_chain_pkg::PTR_W-1:0] stop_pointer_reg,
	input  wire logic [dma_chain_pkg::PTR_W-1:0] next_chain_pointer,
	input  wire logic [dma_chain_pkg::PTR_W-1:0] start_pointer,
	input  wire logic [dma_chain_pkg::CNT_W-1:0] xfer_count,
	input  wire logic                          bus_wait,
	input  wire logic                          frame_done,
	input  wire logic                          in_valid,
	input  wire logic [dma_chain_pkg::DATA_W-1:0] in_data,
	output logic                               in_ready,
	output logic                               out_valid,
	output logic [dma_chain_pkg::DATA_W-1:0]   out_data,
	input  wire logic                          out_ready,
	output logic                               mem_cycle,
	output logic                               dma_error_irq,
	output logic                               dma_normal_end_irq,
	output logic [dma_chain_pkg::STAT_W-1:0]   dma_status_reg,
	output logic [dma_chain_pkg::PTR_W-1:0]    current_chain_pointer,
	output logic [3:0]                         frame_end_irq_counter,
	output logic [1:0]                         priority_reg,
	output logic                               in_initial_state
);
	dma_chain_pkg::dma_state_t state_reg, state_next;
	dma_chain_pkg::irq_enable_t en_reg;
	dma_chain_pkg::word_t buf_reg [2];
	logic        rd_reg, wr_reg;
	logic [5:0]  budget_reg, budget_next;
	logic [1:0]  mcyc_reg;
	logic [7:0]  left_reg;
	logic        run_reg, fct_en_reg, cof_reg, bof_reg, eom_reg, eot_reg;
	logic        end_pend_reg, stop_after_reg;
	logic [3:0]  fct_reg;
	logic [15:0] cda_reg;

	// budgets in states: memory cycles times three plus internal states
	wire [5:0] setup_w = rx_dir ?
		6'(dma_chain_pkg::RX_SETUP_MC_W * dma_chain_pkg::MEM_CYC_STATES
		 + dma_chain_pkg::RX_SETUP_IN_W) :
		6'(dma_chain_pkg::TX_SETUP_MC_W * dma_chain_pkg::MEM_CYC_STATES
		 + dma_chain_pkg::TX_SETUP_IN_W);
	wire [5:0] setup_b = rx_dir ?
		6'(dma_chain_pkg::RX_SETUP_MC_B * dma_chain_pkg::MEM_CYC_STATES
		 + dma_chain_pkg::RX_SETUP_IN_B) :
		6'(dma_chain_pkg::TX_SETUP_MC_B * dma_chain_pkg::MEM_CYC_STATES
		 + dma_chain_pkg::TX_SETUP_IN_B);
	wire [5:0] txsw_w = 6'(dma_chain_pkg::TX_SW_MC_W
		* dma_chain_pkg::MEM_CYC_STATES) + (frame_done ?
		6'(dma_chain_pkg::TX_SW_END_IN_W) :
		6'(dma_chain_pkg::TX_SW_MID_IN_W));
	wire [5:0] txsw_b = 6'(dma_chain_pkg::TX_SW_MC_B
		* dma_chain_pkg::MEM_CYC_STATES) + (frame_done ?
		6'(dma_chain_pkg::TX_SW_END_IN_B) :
		6'(dma_chain_pkg::TX_SW_MID_IN_B));
	wire [5:0] rxsw_w = 6'(dma_chain_pkg::RX_SW_MC_W
		* dma_chain_pkg::MEM_CYC_STATES + dma_chain_pkg::RX_SW_IN_W);
	wire [5:0] rxsw_b = 6'(dma_chain_pkg::RX_SW_MC_B
		* dma_chain_pkg::MEM_CYC_STATES + dma_chain_pkg::RX_SW_IN_B);
	wire [5:0] setup_len = byte_mode ? setup_b : setup_w;
	wire [5:0] sw_len    = rx_dir ? (byte_mode ? rxsw_b : rxsw_w)
	                              : (byte_mode ? txsw_b : txsw_w);

	// two-entry buffer between source and sink
	wire buf_full  = buf_reg[0].valid & buf_reg[1].valid;
	wire xfer_ok   = (state_reg == dma_chain_pkg::ST_XFER) & run_reg;
	wire push      = in_valid & ~buf_full & xfer_ok;
	// pop only a word the sink has been shown; popping the raw entry
	// could drop a word before out_valid ever rose
	wire pop       = out_valid & out_ready;
	wire mem_done  = push & (mcyc_reg == 2'(dma_chain_pkg::MEM_CYC_STATES-1));
	// a wait state holds the cycle one more state
	wire beat      = push & ~bus_wait;
	wire overrun   = in_valid & run_reg & chained_mode
	               & (stop_pointer_reg == cda_reg);
	wire frame_ev  = frame_done & chained_mode & xfer_ok;
	wire fct_wrap  = frame_ev & fct_en_reg & (fct_reg == dma_chain_pkg::FCT_MAX);
	wire block_end = mem_done & beat & (left_reg == 8'h01);
	wire budget_done = (budget_reg == 6'h00_01) & ~bus_wait;

	always_comb begin
		state_next  = state_reg;
		budget_next = budget_reg;
		case (state_reg)
			dma_chain_pkg::ST_IDLE, dma_chain_pkg::ST_HALT: begin
				if (run_reg && chained_mode) begin
					state_next  = dma_chain_pkg::ST_SETUP;
					budget_next = setup_len;
				end else if (run_reg) begin
					state_next  = dma_chain_pkg::ST_XFER;
				end
			end
			dma_chain_pkg::ST_SETUP: begin
				if (budget_done)
					state_next = dma_chain_pkg::ST_XFER;
				else if (!bus_wait)
					budget_next = budget_reg - 6'h00_01;
			end
			dma_chain_pkg::ST_XFER: begin
				if (stop_after_reg && frame_ev)
					state_next = dma_chain_pkg::ST_HALT;
				else if (block_end && !chained_mode)
					state_next = dma_chain_pkg::ST_IDLE;
				else if ((block_end || frame_ev) && chained_mode) begin
					state_next  = dma_chain_pkg::ST_SWTCH;
					budget_next = sw_len;
				end else if (!run_reg)
					state_next = dma_chain_pkg::ST_HALT;
			end
			dma_chain_pkg::ST_SWTCH: begin
				if (budget_done)
					state_next = end_pend_reg ? dma_chain_pkg::ST_IDLE
					                          : dma_chain_pkg::ST_XFER;
				else if (!bus_wait)
					budget_next = budget_reg - 6'h00_01;
			end
			default: state_next = dma_chain_pkg::ST_IDLE;
		endcase
		// abort re-initialises from a suspended state
		if (abort_cmd)
			state_next = dma_chain_pkg::ST_IDLE;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg  <= dma_chain_pkg::ST_IDLE;
			budget_reg <= 6'h00_00;
			// fixed order 0 > 1 > 2 > 3, never rotated
			priority_reg <= dma_chain_pkg::PRIO_RST;
		end else begin
			state_reg  <= state_next;
			budget_reg <= budget_next;
		end
	end

	// memory cycle phase counter, three states per word or byte
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mcyc_reg  <= 2'h0;
			mem_cycle <= 1'b0;
		end else begin
			mem_cycle <= push;
			if (!push || mem_done && beat)
				mcyc_reg <= 2'h0;
			else if (beat)
				mcyc_reg <= mcyc_reg + 2'h1;
		end
	end

	// data buffer; words enter only at the end of a memory cycle
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			buf_reg[0] <= '0;
			buf_reg[1] <= '0;
			rd_reg     <= 1'b0;
			wr_reg     <= 1'b0;
		end else begin
			if (mem_done && beat) begin
				buf_reg[wr_reg] <= '{valid: 1'b1, data: in_data};
				wr_reg          <= ~wr_reg;
			end
			if (pop) begin
				buf_reg[rd_reg].valid <= 1'b0;
				rd_reg                <= ~rd_reg;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			run_reg        <= 1'b0;
			fct_en_reg     <= 1'b0;
			fct_reg        <= dma_chain_pkg::FCT_ZERO;
			en_reg         <= '0;
			cof_reg        <= 1'b0;
			bof_reg        <= 1'b0;
			eom_reg        <= 1'b0;
			eot_reg        <= 1'b0;
			end_pend_reg   <= 1'b0;
			stop_after_reg <= 1'b0;
			cda_reg        <= 16'h0000;
			left_reg       <= dma_chain_pkg::CNT_ZERO;
		end else begin
			if (run_set && state_reg == dma_chain_pkg::ST_IDLE) begin
				run_reg  <= 1'b1;
				cda_reg  <= start_pointer;
				left_reg <= xfer_count;
				end_pend_reg   <= 1'b0;
				stop_after_reg <= 1'b0;
			end else if (run_set) begin
				run_reg <= 1'b1;
			end
			// an overflow halt drops the run bit, so the halt is not left
			// again until software restarts the channel
			if (run_clear || abort_cmd || state_next == dma_chain_pkg::ST_IDLE
			    && state_reg != dma_chain_pkg::ST_IDLE
			    || stop_after_reg && frame_ev)
				run_reg <= 1'b0;
			if (irq_enable_we)
				en_reg <= dma_chain_pkg::irq_enable_t'({4'h0, irq_enable_wr});
			if (fct_enable_set)
				fct_en_reg <= 1'b1;
			if (mem_done && beat && left_reg != dma_chain_pkg::CNT_ZERO)
				left_reg <= left_reg - 8'h01;
			if (state_reg == dma_chain_pkg::ST_SWTCH && budget_done)
				cda_reg <= next_chain_pointer;
			if (block_end && !multi_frame)
				end_pend_reg <= 1'b1;
			// frame-end counter; wrap halts the channel at the next frame end
			if (fct_clear_cmd)
				fct_reg <= dma_chain_pkg::FCT_ZERO;
			if (fct_wrap) begin
				fct_reg        <= dma_chain_pkg::FCT_ZERO;
				stop_after_reg <= 1'b1;
			end else if (frame_ev && fct_en_reg)
				fct_reg <= fct_reg + 4'h1;
			// flags: set beats a same-cycle write-one clear
			cof_reg <= fct_wrap | (cof_reg & ~flag_clear_w1c[0]);
			bof_reg <= overrun | (bof_reg & ~flag_clear_w1c[1]);
			// frame flag also held while the counter is live
			eom_reg <= frame_ev | (fct_en_reg && fct_reg != dma_chain_pkg::FCT_ZERO
			           && !fct_clear_cmd)
			           | (eom_reg & ~flag_clear_w1c[2]);
			// a per-frame event never sets the transfer-end flag
			eot_reg <= (block_end & ~multi_frame)
			           | (eot_reg & ~flag_clear_w1c[3]);
		end
	end

	// requests come from the sticky flags, so initial or halt keeps them
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dma_error_irq      <= 1'b0;
			dma_normal_end_irq <= 1'b0;
			dma_status_reg     <= dma_chain_pkg::STAT_RST;
			current_chain_pointer <= 16'h0000;
			frame_end_irq_counter <= dma_chain_pkg::FCT_ZERO;
			out_valid          <= 1'b0;
			out_data           <= 16'h0000;
			in_ready           <= 1'b0;
			in_initial_state   <= 1'b1;
		end else begin
			dma_error_irq <= (cof_reg & en_reg.counter_overflow_flag)
			               | (bof_reg & en_reg.buffer_overrun_flag);
			dma_normal_end_irq <= (eom_reg & en_reg.frame_end_flag)
			                    | (eot_reg & en_reg.transfer_end_flag);
			dma_status_reg <= {cof_reg, bof_reg, eom_reg, eot_reg,
			                   2'b00, run_reg, 1'b0};
			current_chain_pointer <= cda_reg;
			frame_end_irq_counter <= fct_reg;
			out_valid <= buf_reg[rd_reg].valid & ~pop
			           | buf_reg[~rd_reg].valid;
			out_data  <= pop ? buf_reg[~rd_reg].data : buf_reg[rd_reg].data;
			in_ready  <= ~buf_full & xfer_ok;
			// from the next state, so the flag lines up with the state reg
			in_initial_state <= (state_next == dma_chain_pkg::ST_IDLE);
		end
	end
endmodule : chained_dma_irq_timing
`default_nettype wire

// >>> hdl/dma_chain_pkg.sv
// package for the chained dma controller: constants, states, carrier types
// assumes one 25 MHz clock; one state of the controller is one mclk cycle
`default_nettype none
package dma_chain_pkg;
	// one memory cycle is three states without waits
	localparam int MEM_CYC_STATES   = 3;
	// transmit set-up, mode 0/2/3 and mode 1: memory cycles and internal
	localparam int TX_SETUP_MC_W    = 5;
	localparam int TX_SETUP_IN_W    = 5;
	localparam int TX_SETUP_MC_B    = 8;
	localparam int TX_SETUP_IN_B    = 8;
	// transmit buffer switch, mid frame and frame end internal states
	localparam int TX_SW_MC_W       = 5;
	localparam int TX_SW_MID_IN_W   = 6;
	localparam int TX_SW_END_IN_W   = 10;
	localparam int TX_SW_MC_B       = 8;
	localparam int TX_SW_MID_IN_B   = 9;
	localparam int TX_SW_END_IN_B   = 13;
	// receive set-up and buffer switch
	localparam int RX_SETUP_MC_W    = 3;
	localparam int RX_SETUP_IN_W    = 9;
	localparam int RX_SETUP_MC_B    = 5;
	localparam int RX_SETUP_IN_B    = 8;
	localparam int RX_SW_MC_W       = 5;
	localparam int RX_SW_IN_W       = 11;
	localparam int RX_SW_MC_B       = 8;
	localparam int RX_SW_IN_B       = 10;
	// frame-end counter
	localparam logic [3:0] FCT_MAX  = 4'hf;
	localparam logic [3:0] FCT_ZERO = 4'h0;
	// status bit positions
	localparam int RUN_BIT          = 1;
	localparam int STAT_W           = 8;
	localparam int COF_BIT          = 7;
	localparam int BOF_BIT          = 6;
	localparam int EOM_BIT          = 5;
	localparam int EOT_BIT          = 4;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [3:0] EN_RST   = 4'h0;
	localparam logic [1:0] PRIO_RST = 2'h0;
	localparam int PTR_W            = 16;
	localparam int DATA_W           = 16;
	localparam int CNT_W            = 8;
	localparam logic [7:0] CNT_ZERO = 8'h00;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_XFER  = 5'b00100,
		ST_SWTCH = 5'b01000,
		ST_HALT  = 5'b10000
	} dma_state_t;

	typedef struct packed {
		logic [3:0] unused;
		logic       transfer_end_flag;
		logic       frame_end_flag;
		logic       buffer_overrun_flag;
		logic       counter_overflow_flag;
	} irq_enable_t;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} word_t;
endpackage : dma_chain_pkg
`default_nettype wire

// >>> test/chained_dma_irq_timing_asserts.sv
// port assertions for the chained dma controller
// assumes one clock mclk and an asynchronous active-high rst
`default_nettype none
module chained_dma_irq_timing_asserts (
	input wire logic                              mclk,
	input wire logic                              rst,
	input wire logic                              run_set,
	input wire logic                              chained_mode,
	input wire logic [3:0]                        flag_clear_w1c,
	input wire logic                              in_ready,
	input wire logic                              mem_cycle,
	input wire logic                              dma_error_irq,
	input wire logic                              dma_normal_end_irq,
	input wire logic [dma_chain_pkg::STAT_W-1:0]  dma_status_reg,
	input wire logic [3:0]                        frame_end_irq_counter,
	input wire logic [1:0]                        priority_reg,
	input wire logic                              in_initial_state
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	err_source_a: assert property (
		dma_error_irq |-> dma_status_reg[7] || dma_status_reg[6])
		else $error("error request without a flag");
	end_source_a: assert property (
		dma_normal_end_irq |-> dma_status_reg[5] || dma_status_reg[4])
		else $error("normal-end request without a flag");
	run_start_a: assert property (
		$rose(dma_status_reg[1]) |-> $past(run_set, 2))
		else $error("run bit rose without a start");
	setup_gap_a: assert property (
		$rose(dma_status_reg[1]) && chained_mode |-> !in_ready [*8])
		else $error("data taken before descriptor set-up");
	cof_sticky_a: assert property (
		dma_status_reg[7] && !flag_clear_w1c[0] && !$past(flag_clear_w1c[0])
		|=> dma_status_reg[7])
		else $error("overflow flag dropped by itself");
	bof_sticky_a: assert property (
		dma_status_reg[6] && !flag_clear_w1c[1] && !$past(flag_clear_w1c[1])
		|=> dma_status_reg[6])
		else $error("overrun flag dropped by itself");
	eot_sticky_a: assert property (
		dma_status_reg[4] && !flag_clear_w1c[3] && !$past(flag_clear_w1c[3])
		|=> dma_status_reg[4])
		else $error("transfer end flag dropped by itself");
	eom_hold_a: assert property (
		frame_end_irq_counter != 4'h0 |-> dma_status_reg[5])
		else $error("frame flag low with counter nonzero");
	prio_fixed_a: assert property (priority_reg == 2'h0)
		else $error("priority order changed");
	init_idle_a: assert property (
		in_initial_state && $past(in_initial_state) |-> !in_ready && !mem_cycle)
		else $error("activity in the initial state");
	cover property ($rose(dma_error_irq));
	cover property ($rose(dma_normal_end_irq));
	cover property ($rose(in_ready) && chained_mode);
endmodule : chained_dma_irq_timing_asserts
bind chained_dma_irq_timing chained_dma_irq_timing_asserts i_chk (
	.mclk(mclk), .rst(rst), .run_set(run_set), .chained_mode(chained_mode),
	.flag_clear_w1c(flag_clear_w1c), .in_ready(in_ready),
	.mem_cycle(mem_cycle), .dma_error_irq(dma_error_irq),
	.dma_normal_end_irq(dma_normal_end_irq), .dma_status_reg(dma_status_reg),
	.frame_end_irq_counter(frame_end_irq_counter),
	.priority_reg(priority_reg), .in_initial_state(in_initial_state));
`default_nettype wire

// >>> test/dma_far_side.sv
// far-side model: serial unit feeding words, memory side draining them
// assumes the controller's mclk; changes only just after rising edges
`default_nettype none
module dma_far_side (
	input  wire logic                              mclk,
	input  wire logic                              rst,
	input  wire logic                              slow,
	input  wire logic                              in_ready,
	output logic                                   in_valid,
	output logic [dma_chain_pkg::DATA_W-1:0]       in_data,
	output logic                                   out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			in_valid  <= 1'b0;
			in_data   <= 16'h0000;
			out_ready <= 1'b0;
		end else begin
			in_valid <= 1'b1;
			// a word stands until taken, one per handshake
			if (in_valid && in_ready)
				in_data <= in_data + 16'h0001;
			// slow sink takes every other cycle; with one word per three-state memory cycle the buffer never fills
			out_ready <= slow ? ~out_ready : 1'b1;
		end
	end
endmodule : dma_far_side
`default_nettype wire

// >>> test/chained_dma_irq_timing_test.sv
// bench for the chained dma controller: reset, budgets, flags, requests
// assumes the far-side model feeds the buffer and drains it
`default_nettype none
module chained_dma_irq_timing_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst = 1'b1, byte_mode = 1'b0, chained_mode = 1'b0;
	logic rx_dir = 1'b0, multi_frame = 1'b0, run_set = 1'b0, run_clear = 1'b0;
	logic abort_cmd = 1'b0, fct_clear_cmd = 1'b0, fct_enable_set = 1'b0;
	logic irq_enable_we = 1'b0, frame_done = 1'b0, slow = 1'b0;
	logic bus_wait = 1'b0;
	logic [3:0] irq_enable_wr = 4'h0, flag_clear_w1c = 4'h0;
	logic [15:0] stop_pointer_reg = 16'h8000;
	logic in_valid, in_ready, out_valid, out_ready, mem_cycle, dma_error_irq;
	logic dma_normal_end_irq, in_initial_state;
	logic [15:0] in_data, out_data, current_chain_pointer;
	logic [7:0] dma_status_reg;
	logic [3:0] frame_end_irq_counter;
	logic [1:0] priority_reg;
	int fails = 0, num_checks = 0;
	always #20 mclk = ~mclk;
	chained_dma_irq_timing i_dut (.mclk(mclk), .rst(rst),
		.byte_mode(byte_mode), .chained_mode(chained_mode), .rx_dir(rx_dir),
		.multi_frame(multi_frame), .run_set(run_set), .run_clear(run_clear),
		.abort_cmd(abort_cmd), .fct_clear_cmd(fct_clear_cmd),
		.fct_enable_set(fct_enable_set), .irq_enable_wr(irq_enable_wr),
		.irq_enable_we(irq_enable_we), .flag_clear_w1c(flag_clear_w1c),
		.stop_pointer_reg(stop_pointer_reg), .next_chain_pointer(16'h0080),
		.start_pointer(16'h0040), .xfer_count(8'hff), .bus_wait(bus_wait),
		.frame_done(frame_done), .in_valid(in_valid), .in_data(in_data),
		.in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
		.out_ready(out_ready), .mem_cycle(mem_cycle),
		.dma_error_irq(dma_error_irq), .dma_normal_end_irq(dma_normal_end_irq),
		.dma_status_reg(dma_status_reg),
		.current_chain_pointer(current_chain_pointer),
		.frame_end_irq_counter(frame_end_irq_counter),
		.priority_reg(priority_reg), .in_initial_state(in_initial_state));
	dma_far_side i_far (.mclk(mclk), .rst(rst), .slow(slow),
		.in_ready(in_ready), .in_valid(in_valid), .in_data(in_data),
		.out_ready(out_ready));
	task automatic chk(input string what, input logic [15:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic start_run;
		@(posedge mclk) run_set <= 1'b1;
		@(posedge mclk) run_set <= 1'b0;
	endtask : start_run
	task automatic w1c(input logic [3:0] bits);
		@(posedge mclk) flag_clear_w1c <= bits;
		@(posedge mclk) flag_clear_w1c <= 4'h0;
		repeat (2) @(negedge mclk);
	endtask : w1c
	task automatic stop_run;
		@(posedge mclk) run_clear <= 1'b1;
		@(posedge mclk) run_clear <= 1'b0;
		repeat (2) @(negedge mclk);
		chk("run bit", 16'h0000, 16'(dma_status_reg[1]));
		chk("suspended", 16'h0000, 16'(in_initial_state));
		@(posedge mclk) abort_cmd <= 1'b1;
		@(posedge mclk) abort_cmd <= 1'b0;
		repeat (2) @(negedge mclk);
		chk("aborted", 16'h0001, 16'(in_initial_state));
	endtask : stop_run
	task automatic t_reset;
		chk("status", 16'h0000, 16'(dma_status_reg));
		chk("counter", 16'h0000, 16'(frame_end_irq_counter));
		chk("priority", 16'h0000, 16'(priority_reg));
		chk("initial", 16'h0001, 16'(in_initial_state));
		chk("requests", 16'h0000, 16'({dma_error_irq, dma_normal_end_irq}));
		$display("test reset done");
	endtask : t_reset
	// counts from the run bit rising to the first ready state
	task automatic t_setup(input logic bm, rx, wt, input int budget);
		int n;
		@(posedge mclk);
		byte_mode <= bm;
		rx_dir <= rx;
		chained_mode <= 1'b1;
		start_run();
		n = 0;
		while (dma_status_reg[1] !== 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		n = 0;
		// one wait state inside the set-up stretches it by one state
		if (wt) begin
			@(posedge mclk) bus_wait <= 1'b1;
			@(posedge mclk) bus_wait <= 1'b0;
			n = 1;
		end
		while (in_ready !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		chk("setup states", 16'(budget + 1 + int'(wt)), 16'(n));
		chk("memory cycle", 16'h0001, 16'(mem_cycle));
		n = 0;
		while (out_valid !== 1'b1 && n < 8) begin
			@(negedge mclk);
			n++;
		end
		chk("word out", 16'h0001, 16'(out_valid));
		stop_run();
		$display("test setup %0d done", budget);
	endtask : t_setup
	task automatic t_overrun;
		int n;
		@(posedge mclk);
		stop_pointer_reg <= 16'h0040;
		irq_enable_wr <= 4'h2;
		irq_enable_we <= 1'b1;
		@(posedge mclk) irq_enable_we <= 1'b0;
		start_run();
		n = 0;
		while (dma_status_reg[6] !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
		chk("overrun flag", 16'h0001, 16'(dma_status_reg[6]));
		chk("error request", 16'h0001, 16'(dma_error_irq));
		chk("chain pointer", 16'h0040, current_chain_pointer);
		stop_run();
		chk("request kept", 16'h0001, 16'(dma_error_irq));
		w1c(4'h2);
		chk("overrun cleared", 16'h0000, 16'(dma_status_reg[6]));
		chk("error dropped", 16'h0000, 16'(dma_error_irq));
		@(posedge mclk) stop_pointer_reg <= 16'h8000;
		$display("test overrun done");
	endtask : t_overrun
	task automatic frames(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			// a frame end is only seen once the buffer switch is over
			repeat (40) @(posedge mclk);
			@(posedge mclk) frame_done <= 1'b1;
			@(posedge mclk) frame_done <= 1'b0;
		end
		repeat (2) @(negedge mclk);
	endtask : frames
	task automatic t_frames;
		@(posedge mclk);
		irq_enable_wr <= 4'h5;
		irq_enable_we <= 1'b1;
		multi_frame <= 1'b1;
		fct_enable_set <= 1'b1;
		slow <= 1'b1;
		@(posedge mclk);
		irq_enable_we <= 1'b0;
		fct_enable_set <= 1'b0;
		start_run();
		repeat (40) @(posedge mclk);
		frames(2);
		chk("frame count", 16'h0002, 16'(frame_end_irq_counter));
		chk("frame flag", 16'h0001, 16'(dma_status_reg[5]));
		chk("no transfer end", 16'h0000, 16'(dma_status_reg[4]));
		chk("normal request", 16'h0001, 16'(dma_normal_end_irq));
		chk("next pointer", 16'h0080, current_chain_pointer);
		w1c(4'h4);
		chk("flag held", 16'h0001, 16'(dma_status_reg[5]));
		@(posedge mclk) fct_clear_cmd <= 1'b1;
		@(posedge mclk) fct_clear_cmd <= 1'b0;
		w1c(4'h4);
		chk("frame cleared", 16'h0000, 16'(dma_status_reg[5]));
		frames(16);
		chk("overflow flag", 16'h0001, 16'(dma_status_reg[7]));
		chk("count wrapped", 16'h0000, 16'(frame_end_irq_counter));
		chk("overflow request", 16'h0001, 16'(dma_error_irq));
		w1c(4'h1);
		chk("overflow cleared", 16'h0000, 16'(dma_status_reg[7]));
		frames(1);
		chk("overflow halt", 16'h0000, 16'(dma_status_reg[1]));
		stop_run();
		$display("test frames done");
	endtask : t_frames
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		t_reset();
		t_setup(1'b0, 1'b0, 1'b0, 20);
		t_setup(1'b0, 1'b1, 1'b0, 18);
		t_setup(1'b1, 1'b0, 1'b0, 32);
		t_setup(1'b1, 1'b1, 1'b0, 23);
		t_setup(1'b0, 1'b0, 1'b1, 20);
		t_overrun();
		t_frames();
		report_and_stop();
	end
	// the tests need under 2000 cycles
	initial begin
		#400000;
		fails++;
		report_and_stop();
	end
endmodule : chained_dma_irq_timing_test
`default_nettype wire
